// *** inc/clhi_pkg.sv ***
// Shared constants and types for the character display host port.
// Assumes one 20 MHz clock; all host pins arrive asynchronously.
package clhi_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int EXEC_TIME_NS  = 37000;
    localparam int EXEC_CYC      = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 10;

    // ----------------------------------------------------------------
    // Memory geometry and display address map
    // ----------------------------------------------------------------
    localparam int         DTR_DEPTH    = 80;
    localparam int         UFR_DEPTH    = 64;
    localparam logic [6:0] LEN_ONE      = 7'h50;
    localparam logic [6:0] LEN_TWO      = 7'h28;
    localparam logic [6:0] ONE_LAST     = 7'h4F;
    localparam logic [6:0] LINE1_LAST   = 7'h27;
    localparam logic [6:0] LINE2_BASE   = 7'h40;
    localparam logic [6:0] LINE2_LAST   = 7'h67;
    localparam logic [6:0] AC_ZERO      = 7'h00;
    localparam logic [6:0] AC_ONE       = 7'h01;

    // ----------------------------------------------------------------
    // Instruction field positions
    // ----------------------------------------------------------------
    localparam int INS_SETDD = 7;
    localparam int INS_SETCG = 6;
    localparam int INS_FUNC  = 5;
    localparam int INS_SHIFT = 4;
    localparam int INS_ENTRY = 2;
    localparam int INS_HOME  = 1;
    localparam int FUNC_DL   = 4;
    localparam int FUNC_N    = 3;
    localparam int SHIFT_SC  = 3;
    localparam int SHIFT_RL  = 2;
    localparam int ENTRY_ID  = 1;
    localparam int STAT_BF   = 7;
    localparam int NIB_MSB   = 7;
    localparam int NIB_LSB   = 4;

    // Select/direction pair {register_select, read_write}
    localparam logic [1:0] OP_INSTR = 2'h0;
    localparam logic [1:0] OP_STAT  = 2'h1;
    localparam logic [1:0] OP_DWR   = 2'h2;
    localparam logic [1:0] OP_DRD   = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       if_hi;
        logic       if_lo;
        logic       cs_n;
        logic       sa1;
        logic       sa0;
        logic       en;
        logic       rs;
        logic       rw;
        logic [7:0] db;
    } clhi_pins_t;

    typedef struct packed {
        logic bus8;
        logic two_line;
        logic inc;
        logic to_font;
    } clhi_cfg_t;

    localparam clhi_cfg_t CFG_RESET = '{bus8: 1'b1, two_line: 1'b0, inc: 1'b1, to_font: 1'b0};

endpackage

// *** src/clhi_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes each bit is quasi-static or sampled as a level downstream.
`timescale 1ns/1ns
module clhi_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else if (ce_i) begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // clhi_sync

// *** src/clhi_host_port.sv ***
// Host-side port of a character display controller: holding registers,
// status read, address counter, display and user font RAMs, scan read.
// Assumes host pins are asynchronous; scan inputs come from this clock.
`timescale 1ns/1ns
module clhi_host_port
    import clhi_pkg::*;
#(
    parameter logic [4:0] TGT_ADDR_HI = 5'h0A  // Arbitrary fixed upper address bits
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    input  wire logic       interface_select_hi_i,
    input  wire logic       interface_select_lo_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       target_addr_bit0_i,
    input  wire logic       target_addr_bit1_i,
    input  wire logic       enable_i,
    input  wire logic       register_select_i,
    input  wire logic       read_write_i,
    input  wire logic [7:0] db_i,
    output logic      [7:0] db_o,
    output logic            db_oe_o,
    output logic            internal_op_pending_o,
    output logic      [6:0] target_addr_o,
    input  wire logic       scan_line_i,
    input  wire logic [6:0] scan_col_i,
    output logic      [7:0] scan_code_o,
    output logic            scan_user_font_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_BUSY, ST_FETCH} clhi_state_t;

    // Edges after reset until the strap levels have crossed the synchroniser
    localparam logic [1:0] STRAP_EDGES = 2'h3;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic is_par(input clhi_pins_t p);
        return p.if_hi;
    endfunction

    function automatic logic [6:0] dtr_index(input logic [6:0] a, input logic two);
        return (two && a[6]) ? a - LINE2_BASE + LEN_TWO : a;
    endfunction

    function automatic logic [6:0] ac_step(input logic [6:0] a, input clhi_cfg_t c);
        logic [6:0] r;
        r = c.inc ? a + AC_ONE : a - AC_ONE;
        if (c.to_font) begin
            r[6] = 1'b0;
        end else if (!c.two_line) begin
            if (c.inc && a == ONE_LAST) r = AC_ZERO;
            else if (!c.inc && a == AC_ZERO) r = ONE_LAST;
        end else if (c.inc) begin
            if (a == LINE1_LAST) r = LINE2_BASE;
            else if (a == LINE2_LAST) r = AC_ZERO;
        end else begin
            if (a == LINE2_BASE) r = LINE1_LAST;
            else if (a == AC_ZERO) r = LINE2_LAST;
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisation and access decode
    // ----------------------------------------------------------------
    clhi_pins_t  pins;
    clhi_state_t state_reg;
    clhi_cfg_t   cfg_reg;
    clhi_cfg_t   cfg_mv;
    logic [CNT_W-1:0] cnt_reg;
    logic [7:0]  instruction_holding_reg;
    logic [7:0]  data_holding_reg;
    logic [6:0]  address_counter_reg;
    logic [6:0]  shift_reg;
    logic [3:0]  nib_hold_reg;
    logic        nib_ph_reg;
    logic        e_prev_reg;
    logic [1:0]  strap_cnt_reg;
    logic [7:0]  dtr_mem [DTR_DEPTH];
    logic [7:0]  ufr_mem [UFR_DEPTH];
    logic [7:0]  wbyte;
    logic [7:0]  ram_rd;
    logic [7:0]  rd_byte;
    logic [7:0]  rd_out;
    logic [6:0]  didx;
    logic [6:0]  scan_idx;
    logic [7:0]  scan_sum;
    logic [6:0]  line_len;
    logic        par;
    logic        sel;
    logic        acc;
    logic        nib;
    logic        byte_done;
    logic        idle;
    logic        instr_ok;
    logic        dwr_ok;
    logic        drd_ok;
    logic [1:0]  op;

    clhi_sync #(
        .W ($bits(clhi_pins_t))
    ) u_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .ce_i    (ce_i),
        .d_i     ({interface_select_hi_i, interface_select_lo_i, chip_select_n_i,
                   target_addr_bit1_i, target_addr_bit0_i, enable_i,
                   register_select_i, read_write_i, db_i}),
        .q_o     (pins)
    );

    assign par       = is_par(pins);
    assign sel       = par | ~pins.cs_n;
    assign acc       = ce_i & e_prev_reg & ~pins.en & sel;
    assign nib       = par & ~cfg_reg.bus8;
    assign byte_done = acc & (~nib | nib_ph_reg);
    assign wbyte     = nib ? {nib_hold_reg, pins.db[NIB_MSB:NIB_LSB]} : pins.db;
    assign op        = {pins.rs, pins.rw};
    assign idle      = (state_reg == ST_IDLE);
    assign instr_ok  = byte_done & (op == OP_INSTR) & idle;
    assign dwr_ok    = byte_done & (op == OP_DWR) & idle;
    assign drd_ok    = byte_done & (op == OP_DRD) & idle;
    assign didx      = dtr_index(address_counter_reg, cfg_reg.two_line);

    always_comb begin
        cfg_mv     = cfg_reg;
        cfg_mv.inc = instruction_holding_reg[SHIFT_RL];
    end

    // ----------------------------------------------------------------
    // Strobe edge, nibble pairing
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            e_prev_reg <= 1'b0;
        end else if (ce_i) begin
            e_prev_reg <= pins.en;
        end
    end

    // Phase also toggles on refused instructions so the pairing never slips
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            nib_ph_reg   <= 1'b0;
            nib_hold_reg <= 4'h0;
        end else if (ce_i) begin
            if (!nib) begin
                nib_ph_reg <= 1'b0;
            end else if (acc) begin
                nib_ph_reg <= ~nib_ph_reg;
                if (!nib_ph_reg) nib_hold_reg <= pins.db[NIB_MSB:NIB_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // Internal operation sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else if (ce_i) begin
            case (state_reg)
                ST_IDLE: begin
                    if (instr_ok) state_reg <= ST_EXEC;
                    else if (drd_ok) state_reg <= ST_FETCH;
                end
                ST_EXEC: begin
                    state_reg <= ST_BUSY;
                    cnt_reg   <= CNT_W'(EXEC_CYC - 1);
                end
                ST_BUSY: begin
                    if (cnt_reg == '0) state_reg <= ST_FETCH;
                    else cnt_reg <= cnt_reg - 1'b1;
                end
                ST_FETCH: state_reg <= ST_IDLE;
                default:  state_reg <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Holding registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            instruction_holding_reg <= 8'h00;
        end else if (ce_i && instr_ok) begin
            instruction_holding_reg <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            data_holding_reg <= 8'h00;
        end else if (ce_i) begin
            if (dwr_ok) data_holding_reg <= wbyte;
            else if (state_reg == ST_FETCH) data_holding_reg <= ram_rd;
        end
    end

    // ----------------------------------------------------------------
    // Configuration, address counter, display shift
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cfg_reg             <= CFG_RESET;
            address_counter_reg <= AC_ZERO;
            shift_reg           <= AC_ZERO;
        end else if (ce_i) begin
            if (state_reg == ST_EXEC) begin
                if (instruction_holding_reg[INS_SETDD]) begin
                    address_counter_reg <= instruction_holding_reg[6:0];
                    cfg_reg.to_font     <= 1'b0;
                end else if (instruction_holding_reg[INS_SETCG]) begin
                    address_counter_reg <= {1'b0, instruction_holding_reg[5:0]};
                    cfg_reg.to_font     <= 1'b1;
                end else if (instruction_holding_reg[INS_FUNC]) begin
                    cfg_reg.bus8     <= instruction_holding_reg[FUNC_DL];
                    cfg_reg.two_line <= instruction_holding_reg[FUNC_N];
                end else if (instruction_holding_reg[INS_SHIFT]) begin
                    if (instruction_holding_reg[SHIFT_SC]) begin
                        // Only the window offset moves; RAM stays untouched
                        if (instruction_holding_reg[SHIFT_RL])
                            shift_reg <= (shift_reg == AC_ZERO) ? line_len - AC_ONE
                                                               : shift_reg - AC_ONE;
                        else
                            shift_reg <= (shift_reg + AC_ONE >= line_len) ? AC_ZERO
                                                                         : shift_reg + AC_ONE;
                    end else begin
                        address_counter_reg <= ac_step(address_counter_reg, cfg_mv);
                    end
                end else if (instruction_holding_reg[INS_ENTRY]) begin
                    cfg_reg.inc <= instruction_holding_reg[ENTRY_ID];
                end else if (instruction_holding_reg[INS_HOME]) begin
                    address_counter_reg <= AC_ZERO;
                    shift_reg           <= AC_ZERO;
                end
            end else if (dwr_ok || drd_ok) begin
                address_counter_reg <= ac_step(address_counter_reg, cfg_reg);
            end
        end
    end

    // ----------------------------------------------------------------
    // Display and user font RAM
    // ----------------------------------------------------------------
    always_comb begin
        if (cfg_reg.to_font) ram_rd = ufr_mem[address_counter_reg[5:0]];
        else if (didx < LEN_ONE) ram_rd = dtr_mem[didx];
        else ram_rd = 8'h00;
    end

    // Two-line map gaps: writes to 0x28-0x3F land in line two's bank; writes to 0x68-0x7F are dropped
    always_ff @(posedge clk_i) begin
        if (ce_i && dwr_ok) begin
            if (cfg_reg.to_font) ufr_mem[address_counter_reg[5:0]] <= wbyte;
            else if (didx < LEN_ONE) dtr_mem[didx] <= wbyte;
        end
    end

    // ----------------------------------------------------------------
    // Scan read: visible position to display RAM code
    // ----------------------------------------------------------------
    assign line_len = cfg_reg.two_line ? LEN_TWO : LEN_ONE;

    always_comb begin
        scan_sum = {1'b0, scan_col_i} + {1'b0, shift_reg};
        if (scan_sum >= {1'b0, line_len}) scan_sum = scan_sum - {1'b0, line_len};
        // Line two starts at its own bank at index 0x28, right after line one's end
        scan_idx = scan_sum[6:0] + ((cfg_reg.two_line && scan_line_i) ? LEN_TWO
                                                                      : AC_ZERO);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            scan_code_o      <= 8'h00;
            scan_user_font_o <= 1'b0;
        end else if (ce_i) begin
            scan_code_o      <= (scan_idx < LEN_ONE) ? dtr_mem[scan_idx] : 8'h00;
            scan_user_font_o <= (scan_idx < LEN_ONE) &&
                                (dtr_mem[scan_idx][NIB_MSB:NIB_LSB] == 4'h0);
        end
    end

    // ----------------------------------------------------------------
    // Host read data, busy, strapped address
    // ----------------------------------------------------------------
    // Instruction register has no read path at all
    assign rd_byte = pins.rs ? data_holding_reg
                             : {~idle & par, address_counter_reg};
    assign rd_out  = !nib ? rd_byte
                   : nib_ph_reg ? {rd_byte[NIB_LSB-1:0], 4'h0}
                                : {rd_byte[NIB_MSB:NIB_LSB], 4'h0};

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            db_o                  <= 8'h00;
            db_oe_o               <= 1'b0;
            internal_op_pending_o <= 1'b0;
        end else if (ce_i) begin
            db_o                  <= rd_out;
            db_oe_o               <= pins.en & pins.rw & par;
            internal_op_pending_o <= ~idle;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            strap_cnt_reg <= 2'h0;
            target_addr_o <= 7'h00;
        end else if (ce_i && strap_cnt_reg != STRAP_EDGES) begin
            // Synchroniser is cleared by reset, so the last capture is the valid one
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            target_addr_o <= {TGT_ADDR_HI, pins.sa1, pins.sa0};
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_busy_instr_drop: assert property (byte_done && op == OP_INSTR && !idle
        |=> $stable(instruction_holding_reg)) else $error("instr taken while busy");
    a_busy_sequence: assert property (ce_i && instr_ok
        |=> state_reg == ST_EXEC ##1 state_reg == ST_BUSY) else $error("busy not entered");
    a_write_to_ram: assert property (ce_i && dwr_ok && !cfg_reg.to_font && didx < LEN_ONE
        |=> dtr_mem[$past(didx)] == $past(wbyte)) else $error("RAM not written");
    a_read_prefetch: assert property (ce_i && drd_ok
        |=> state_reg == ST_FETCH ##1 data_holding_reg == $past(ram_rd)) else $error("no prefetch");
    a_ac_increment: assert property (ce_i && dwr_ok && cfg_reg.inc && !cfg_reg.to_font
        && !cfg_reg.two_line && address_counter_reg < ONE_LAST
        |=> address_counter_reg == $past(address_counter_reg) + AC_ONE) else $error("AC step");
    a_line_jump: assert property (ce_i && dwr_ok && cfg_reg.inc && !cfg_reg.to_font
        && cfg_reg.two_line && address_counter_reg == LINE1_LAST
        |=> address_counter_reg == LINE2_BASE) else $error("line two jump");
    a_serial_no_drive: assert property (ce_i && !par
        |=> !db_oe_o) else $error("bus driven in serial mode");
    a_cs_ignore: assert property (ce_i && !par && pins.cs_n && idle
        |=> idle && $stable(data_holding_reg)) else $error("deselected access");
    a_nibble_order: assert property (ce_i && nib && acc && !nib_ph_reg
        |=> nib_ph_reg && nib_hold_reg == $past(pins.db[NIB_MSB:NIB_LSB])) else $error("nibble");
    a_strap_capture: assert property (ce_i && strap_cnt_reg != STRAP_EDGES
        |=> target_addr_o[1:0] == $past({pins.sa1, pins.sa0})) else $error("strap");

    c_instr_accept: cover property (instr_ok ##1 state_reg == ST_EXEC);
    c_nibble_read:  cover property (nib && drd_ok);
    c_status_busy:  cover property (db_oe_o && !idle);
    c_shift_done:   cover property (state_reg == ST_EXEC && shift_reg != AC_ZERO);

endmodule // clhi_host_port

// *** verif/clhi_host_model.sv ***
// Host processor model: strobes the parallel pins and polls the busy flag.
// Assumes the bench calls its tasks; pins move on the falling clock edge.
`timescale 1ns/1ns
module clhi_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] db_o_i,
    output logic            enable_o,
    output logic            rs_o,
    output logic            rw_o,
    output logic      [7:0] db_o
);
    logic nib = 1'b0;
    initial begin
        enable_o = 1'b0;
        rs_o = 1'b0;
        rw_o = 1'b1;
        db_o = 8'h00;
    end
    // High and low phases well over the two cycles the synchroniser needs
    task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk_i);
        rs_o = rs;
        rw_o = rw;
        db_o = rw ? ~db_o : d; // Released bus shows no stale value
        enable_o = 1'b1;
        repeat (5) @(negedge clk_i);
        q = db_o_i;
        enable_o = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic acc(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
        logic [7:0] h;
        if (nib) begin
            strobe(rs, rw, {d[7:4], ~d[7:4]}, h);
            strobe(rs, rw, {d[3:0], ~d[3:0]}, q);
            q = {h[7:4], q[7:4]};
        end else begin
            strobe(rs, rw, d, q);
        end
    endtask
    task automatic wait_idle(output logic [7:0] s);
        s = 8'h80;
        for (int i = 0; i < 120 && s[7] !== 1'b0; i++) begin
            acc(1'b0, 1'b1, 8'h00, s);
        end
    endtask
endmodule // clhi_host_model

// *** verif/char_lcd_host_interface_tb.sv ***
// Self-checking bench for the display host port with a host model.
// Assumes the package constants and the NOTES timing of the design.
`timescale 1ns/1ns
module char_lcd_host_interface_tb;
    import clhi_pkg::*;
    logic       clk_i = 1'b0, rst_b_i = 1'b0, if_hi = 1'b1, cs_n = 1'b1, sline = 1'b0;
    logic       en, rs, rw, oe, busy, ufont, oe_ser = 1'b0;
    logic [7:0] db_i, db_o, code, s;
    logic [6:0] tgt, scol = 7'h00;
    int         mismatches = 0, num_checks = 0;
    clhi_host_model i_host (.clk_i(clk_i), .db_o_i(db_o), .enable_o(en), .rs_o(rs),
                            .rw_o(rw), .db_o(db_i));
    clhi_host_port i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
        .interface_select_hi_i(if_hi), .interface_select_lo_i(1'b0), .chip_select_n_i(cs_n),
        .target_addr_bit0_i(1'b0), .target_addr_bit1_i(1'b1), .enable_i(en),
        .register_select_i(rs), .read_write_i(rw), .db_i(db_i), .db_o(db_o), .db_oe_o(oe),
        .internal_op_pending_o(busy), .target_addr_o(tgt), .scan_line_i(sline),
        .scan_col_i(scol), .scan_code_o(code), .scan_user_font_o(ufont));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) if (!if_hi && oe) oe_ser <= 1'b1;
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ins(input logic [7:0] d);
        i_host.acc(1'b0, 1'b0, d, s);
        i_host.wait_idle(s);
    endtask
    task automatic scan(input logic l, input logic [6:0] c, input logic [7:0] exp);
        sline = l;
        scol = c;
        repeat (2) @(negedge clk_i);
        check("scan code", exp, code);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("oe after reset", 8'h00, {7'h00, oe});
        check("busy after reset", 8'h00, {7'h00, busy});
        check("target address", {1'b0, 5'h0A, 2'h2}, {1'b0, tgt});
    endtask
    task automatic t_busy();
        i_host.acc(1'b0, 1'b0, 8'h85, s);
        check("busy pin", 8'h01, {7'h00, busy});
        i_host.acc(1'b0, 1'b1, 8'h00, s);
        check("status busy bit", 8'h01, {7'h00, s[7]});
        i_host.acc(1'b0, 1'b0, 8'h90, s);
        i_host.wait_idle(s);
        check("status counter", 8'h05, s);
    endtask
    task automatic t_data();
        i_host.acc(1'b1, 1'b0, 8'h41, s);
        i_host.acc(1'b1, 1'b0, 8'h42, s);
        i_host.acc(1'b0, 1'b1, 8'h00, s);
        check("counter after writes", 8'h07, s);
        ins(8'h85);
        i_host.acc(1'b1, 1'b1, 8'h00, s);
        check("first read", 8'h41, s);
        i_host.acc(1'b1, 1'b1, 8'h00, s);
        check("second read", 8'h42, s);
        scan(1'b0, 7'h05, 8'h41);
    endtask
    task automatic t_lines();
        ins(8'h38);
        ins(8'hC0);
        i_host.acc(1'b1, 1'b0, 8'h03, s);
        scan(1'b1, 7'h00, 8'h03);
        check("user font", 8'h01, {7'h00, ufont});
        ins(8'hA7);
        i_host.acc(1'b1, 1'b0, 8'h11, s);
        i_host.acc(1'b0, 1'b1, 8'h00, s);
        check("line two jump", 8'h40, s);
    endtask
    task automatic t_serial();
        if_hi = 1'b0;
        repeat (4) @(negedge clk_i);
        i_host.acc(1'b1, 1'b0, 8'h55, s);
        cs_n = 1'b0;
        i_host.acc(1'b1, 1'b0, 8'h66, s);
        i_host.acc(1'b0, 1'b1, 8'h00, s);
        check("serial drive", 8'h00, {7'h00, oe_ser});
        if_hi = 1'b1;
        scan(1'b1, 7'h00, 8'h66);
        ins(8'h18);
        scan(1'b1, 7'h27, 8'h66);
    endtask
    task automatic t_nibble();
        i_host.acc(1'b0, 1'b0, 8'h28, s);
        i_host.nib = 1'b1;
        i_host.wait_idle(s);
        check("nibble idle", 8'h41, s);
        ins(8'h8A);
        check("nibble status", 8'h0A, s);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_reset();
        t_busy();
        t_data();
        t_lines();
        t_serial();
        t_nibble();
        summarize();
    end
endmodule // char_lcd_host_interface_tb
